// file: act_bc_prescaler.sv
`timescale 1ns/10ps
module act_bc_prescaler (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       improved_i,
	input  wire logic [1:0] sel_i,
	input  wire logic [3:0] imp_div_i,
	output logic            tick_o
);
	// ==========================================================
	// divisor selection
	logic [4:0] div;     // active divisor
	logic [4:0] tbl_div; // compatibility table value
	logic [4:0] cnt;     // cycles left to next tick

	assign tbl_div = (sel_i == 2'h0) ? act_pkg::DIV_CODE0 :
	                 (sel_i == 2'h1) ? act_pkg::DIV_CODE1 :
	                 (sel_i == 2'h2) ? act_pkg::DIV_CODE2 : act_pkg::DIV_CODE3;
	// improved mode: divide by value plus two, never below two
	assign div = improved_i ? ({1'b0, imp_div_i} + act_pkg::IMP_DIV_MIN) : tbl_div;

	// ==========================================================
	// enable pulse, one system clock wide
	// the reload value is taken at the tick, so a divisor change
	// mid-period only shows from the next period on
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt    <= 5'h00;
			tick_o <= 1'b0;
		end else if (cnt == 5'h00) begin
			cnt    <= div - 5'h01;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt - 5'h01;
			tick_o <= 1'b0;
		end
	end

	// ==========================================================
	// checks
	property p_tick_single;
		@(posedge clk_i) disable iff (!rst_n_i)
		tick_o |=> !tick_o;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("basic clock tick too long");

	property p_div4_gap;
		@(posedge clk_i) disable iff (!rst_n_i)
		(tick_o && !improved_i && $stable(improved_i) && sel_i == 2'h0 && $stable(sel_i))
			|=> !tick_o [*3];
	endproperty
	a_div4_gap: assert property (p_div4_gap) else $error("divide by 4 period short");
endmodule

// file: act_front_model.sv
`timescale 1ns/10ps
// ==========================================================
// analog front end stand-in: comparator, range flags, settle
module act_front_model (
	input  wire logic       clk_i,
	input  wire logic       busy_i,    // converter owns the input
	input  wire logic [9:0] val_i,     // level to hand back
	input  wire logic       under_i,   // input below ground
	input  wire logic       over_i,    // input above reference
	input  wire logic       settle_i,  // reference noise settled
	output logic      [9:0] result_o,
	output logic            under_o,
	output logic            over_o,
	output logic            cal_done_o
);
	logic [9:0] last = 10'h000;  // last level put on the lines

	// ==========================================================
	// released lines toggle, so stale data never looks valid
	always @(posedge clk_i) begin
		if (busy_i) begin
			last <= val_i;
		end else begin
			last <= ~last;
		end
	end

	assign result_o   = busy_i ? val_i : last;
	assign under_o    = busy_i ? under_i : last[0];
	assign over_o     = busy_i ? over_i : last[1];
	assign cal_done_o = settle_i;
endmodule

// file: act_pkg.sv
package act_pkg;
	// ==========================================================
	// register map (byte addresses on the plain port)
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;    // converter_control_word
	localparam logic [3:0]  ADDR_STAT      = 4'h4;    // status, read only
	localparam logic [3:0]  ADDR_RES       = 4'h8;    // result, read only
	localparam logic [3:0]  ADDR_SYS       = 4'hc;    // system_config_one + master clock
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [2:0]  SYS_RESET      = 3'h0;

	// ==========================================================
	// control word fields, then system config fields
	localparam int          START_BIT      = 0;       // write 1 starts a conversion
	localparam int          RES8_BIT       = 1;       // 1: 8-bit resolution
	localparam int          PCAL_OFF_BIT   = 2;       // 1: post-calibration off
	localparam int          IMPROVED_BIT   = 3;       // 1: improved clock mechanism
	localparam int          IMP_DIV_LSB    = 4;       // improved divider, 4 bits
	localparam int          STS_LSB        = 12;      // sample_time_select
	localparam int          BCS_LSB        = 14;      // basic_clock_select
	localparam int          HALVE_BIT      = 0;       // cpu_clock_halving
	localparam int          MCC_LSB        = 1;       // master_clock_config, 2 bits

	// ==========================================================
	// status bits
	localparam int          ST_BUSY_BIT    = 0;
	localparam int          ST_CAL_BIT     = 1;
	localparam int          ST_VALID_BIT   = 2;

	// ==========================================================
	// timing figures
	localparam logic [4:0]  DIV_CODE0      = 5'h04;   // divide by 4
	localparam logic [4:0]  DIV_CODE1      = 5'h02;   // divide by 2
	localparam logic [4:0]  DIV_CODE2      = 5'h10;   // divide by 16
	localparam logic [4:0]  DIV_CODE3      = 5'h08;   // divide by 8
	localparam logic [4:0]  IMP_DIV_MIN    = 5'h02;   // improved divider floor
	localparam logic [6:0]  SAMPLE_BASE    = 7'h08;   // 8 basic clocks at code 00
	localparam logic [6:0]  CONV_10_POST   = 7'h34;   // 52 basic clocks
	localparam logic [6:0]  CONV_8_POST    = 7'h2c;   // 44 basic clocks
	localparam logic [6:0]  PCAL_SAVING    = 7'h0c;   // 12 basic clocks
	localparam logic [2:0]  LOAD_SYS_CYC   = 3'h6;    // result load, system clocks
	localparam int          CAL_MIN_BC     = 484;     // reset calibration floor
	localparam int          CAL_MAX_BC     = 11696;   // reset calibration ceiling
	localparam logic [9:0]  RES_ZERO       = 10'h000; // input below ground
	localparam logic [9:0]  RES_FULL       = 10'h3ff; // input above reference

	// conversion sequencer phases
	typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONVERT, PH_LOAD} act_phase_e;
endpackage

// file: act_timing.sv
`timescale 1ns/10ps
// Function
// - prescaler divides system clock by 4,2,16,8
// - sample time is 8,16,32,64 basic clocks
// - 10-bit post-calibrated conversion: 52 clocks plus load
// - 8-bit post-calibrated conversion: 44 basic clocks
// - post-calibration off saves 12 basic clocks
// - conversion is sample, determination, result load
// - underrange gives zero, overrange gives all ones
// - reset calibration lasts 484 to 11696 clocks
// - conversions during calibration run and extend it
// - compatibility encodings or improved divider selectable
// - cpu_clock_halving picks master clock or half
// - system clock runs at the cpu clock rate
// - master_clock_config selects master clock mechanism
module act_timing #(
	parameter int CAL_MIN_BC = act_pkg::CAL_MIN_BC,
	parameter int CAL_MAX_BC = act_pkg::CAL_MAX_BC
) (
	input  wire logic        CLOCK_I,
	input  wire logic        RST_N_I,
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [15:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [15:0] RDATA_O,
	input  wire logic [9:0]  ANA_RESULT_I,
	input  wire logic        ANA_UNDER_I,
	input  wire logic        ANA_OVER_I,
	input  wire logic        CAL_DONE_I,
	output logic             SAMPLE_O,
	output logic             CONVERT_O,
	output logic             CAL_O,
	output logic             BUSY_O,
	output logic             CPU_CLOCK_HALVING_O,
	output logic      [1:0]  MASTER_CLOCK_CONFIG_O
);
	// ==========================================================
	// state
	localparam int SYNC_W = 13;                     // result, under, over, cal done
	act_pkg::act_phase_e state;                     // sequencer phase
	act_pkg::act_phase_e next_state;
	logic [15:0]       ctrl;                        // converter_control_word
	logic [2:0]        sysreg;                      // halving + master clock config
	logic [9:0]        result;                      // last committed result
	logic              res_valid;                   // sticky, cleared by result read
	logic [6:0]        bc_cnt;                      // basic clocks in current phase
	logic [6:0]        next_bc_cnt;
	logic [2:0]        ld_cnt;                      // system clocks in load phase
	logic [2:0]        next_ld_cnt;
	logic              cal_active;                  // reset calibration running
	logic [13:0]       cal_cnt;                     // calibration basic clocks
	logic [SYNC_W-1:0] s1, s2, s3, filt;            // pin synchroniser stages
	logic              bc_tick;                     // basic clock enable

	// ==========================================================
	// decode
	wire               wr_ctrl   = WR_I && (ADDR_I == act_pkg::ADDR_CTRL);
	wire               wr_sys    = WR_I && (ADDR_I == act_pkg::ADDR_SYS);
	wire               rd_res    = RD_I && (ADDR_I == act_pkg::ADDR_RES);
	wire               start_req = wr_ctrl && WDATA_I[act_pkg::START_BIT];
	wire               res8      = ctrl[act_pkg::RES8_BIT];
	wire               pcal_off  = ctrl[act_pkg::PCAL_OFF_BIT];
	wire        [1:0]  sts       = ctrl[act_pkg::STS_LSB +: 2];
	wire        [9:0]  ana_res   = filt[9:0];
	wire               ana_under = filt[10];
	wire               ana_over  = filt[11];
	wire               cal_done  = filt[12];
	wire               busy      = (state != act_pkg::PH_IDLE);

	// sample length: 8 shifted left by the select code
	wire        [6:0]  sample_target = act_pkg::SAMPLE_BASE << sts;
	// determination length by resolution, less the post-calibration
	wire        [6:0]  conv_base = res8 ? act_pkg::CONV_8_POST
	                                    : act_pkg::CONV_10_POST;
	wire        [6:0]  conv_target = pcal_off ? (conv_base - act_pkg::PCAL_SAVING)
	                                          : conv_base;
	wire        [6:0]  sample_last = sample_target - 7'h01;
	wire        [6:0]  conv_last   = conv_target - 7'h01;
	wire        [2:0]  load_last   = act_pkg::LOAD_SYS_CYC - 3'h1;
	wire               commit      = (state == act_pkg::PH_LOAD) && (ld_cnt == load_last);
	// underrange wins should the front end flag both
	wire        [9:0]  clamped = ana_under ? act_pkg::RES_ZERO :
	                             ana_over  ? act_pkg::RES_FULL : ana_res;

	// calibration advances only while no conversion runs, so each
	// conversion pushes its end out by its own length
	wire               cal_step = cal_active && bc_tick && !busy && !start_req;
	wire               cal_end  = cal_step &&
	                              (((cal_cnt >= 14'(CAL_MIN_BC - 1)) && cal_done) ||
	                               (cal_cnt == 14'(CAL_MAX_BC - 1)));

	wire        [15:0] stat_word = {13'h0000, res_valid, cal_active, busy};
	wire        [15:0] rd_mux = (ADDR_I == act_pkg::ADDR_CTRL) ? ctrl :
	                            (ADDR_I == act_pkg::ADDR_STAT) ? stat_word :
	                            (ADDR_I == act_pkg::ADDR_RES)  ? {6'h00, result} :
	                            (ADDR_I == act_pkg::ADDR_SYS)  ? {13'h0000, sysreg} :
	                            16'h0000;                                    // unmapped

	// ==========================================================
	// basic clock prescaler
	act_bc_prescaler u_presc (
		.clk_i      (CLOCK_I),
		.rst_n_i    (RST_N_I),
		.improved_i (ctrl[act_pkg::IMPROVED_BIT]),
		.sel_i      (ctrl[act_pkg::BCS_LSB +: 2]),
		.imp_div_i  (ctrl[act_pkg::IMP_DIV_LSB +: 4]),
		.tick_o     (bc_tick)
	);

	// ==========================================================
	// pin synchroniser, three stages
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= {CAL_DONE_I, ANA_OVER_I, ANA_UNDER_I, ANA_RESULT_I};
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_filt
			always_ff @(posedge CLOCK_I) begin
				if (!RST_N_I) begin
					filt[gi] <= 1'b0;
				end else if (s2[gi] == s3[gi]) begin
					filt[gi] <= s3[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// sequencer next state
	always_comb begin
		next_state  = state;
		next_bc_cnt = bc_cnt;
		next_ld_cnt = ld_cnt;
		case (state)
			act_pkg::PH_IDLE: begin
				// start while busy is dropped; while calibrating it runs
				if (start_req) begin
					next_state  = act_pkg::PH_SAMPLE;
					next_bc_cnt = 7'h00;
				end
			end
			act_pkg::PH_SAMPLE: begin
				if (bc_tick && bc_cnt == sample_last) begin
					next_state  = act_pkg::PH_CONVERT;
					next_bc_cnt = 7'h00;
				end else if (bc_tick) begin
					next_bc_cnt = bc_cnt + 7'h01;
				end
			end
			act_pkg::PH_CONVERT: begin
				if (bc_tick && bc_cnt == conv_last) begin
					next_state  = act_pkg::PH_LOAD;
					next_ld_cnt = 3'h0;
				end else if (bc_tick) begin
					next_bc_cnt = bc_cnt + 7'h01;
				end
			end
			act_pkg::PH_LOAD: begin
				// counted in system clocks, not basic clocks
				if (ld_cnt == load_last) begin
					next_state = act_pkg::PH_IDLE;
				end else begin
					next_ld_cnt = ld_cnt + 3'h1;
				end
			end
			default: next_state = act_pkg::PH_IDLE;
		endcase
	end

	// ==========================================================
	// sequencer registers and phase outputs
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			state     <= act_pkg::PH_IDLE;
			bc_cnt    <= 7'h00;
			ld_cnt    <= 3'h0;
			SAMPLE_O  <= 1'b0;
			CONVERT_O <= 1'b0;
			BUSY_O    <= 1'b0;
		end else begin
			state     <= next_state;
			bc_cnt    <= next_bc_cnt;
			ld_cnt    <= next_ld_cnt;
			SAMPLE_O  <= (next_state == act_pkg::PH_SAMPLE);
			CONVERT_O <= (next_state == act_pkg::PH_CONVERT);
			BUSY_O    <= (next_state != act_pkg::PH_IDLE);
		end
	end

	// ==========================================================
	// result register; a new result beats a read-clear
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			result    <= act_pkg::RES_ZERO;
			res_valid <= 1'b0;
		end else begin
			if (commit) begin
				result <= clamped;
			end
			res_valid <= commit || (res_valid && !rd_res);
		end
	end

	// ==========================================================
	// reset calibration, starts active out of reset
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			cal_active <= 1'b1;
			cal_cnt    <= 14'h0000;
			CAL_O      <= 1'b1;
		end else begin
			if (cal_end) begin
				cal_active <= 1'b0;
			end
			if (cal_step) begin
				cal_cnt <= cal_cnt + 14'h0001;
			end
			CAL_O <= cal_active && !cal_end;
		end
	end

	// ==========================================================
	// software registers
	// start bit is a command, it is never stored
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			ctrl <= act_pkg::CTRL_RESET;
			sysreg <= act_pkg::SYS_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl <= WDATA_I & ~(16'h0001 << act_pkg::START_BIT);
			end
			if (wr_sys) begin
				sysreg <= WDATA_I[2:0];
			end
		end
	end

	// clock steering straps leave as registered levels; the clock
	// unit outside does the actual division, so this block's
	// CLOCK_I is the system clock at the cpu rate
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			CPU_CLOCK_HALVING_O   <= 1'b0;
			MASTER_CLOCK_CONFIG_O <= 2'h0;
		end else begin
			CPU_CLOCK_HALVING_O   <= sysreg[act_pkg::HALVE_BIT];
			MASTER_CLOCK_CONFIG_O <= sysreg[act_pkg::MCC_LSB +: 2];
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			RDATA_O <= 16'h0000;
		end else begin
			RDATA_O <= RD_I ? rd_mux : 16'h0000;
		end
	end

	// ==========================================================
	// checks and their helpers
	logic [7:0] ph_ticks;                               // ticks seen in phase
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I || state != next_state) begin
			ph_ticks <= 8'h00;
		end else if (bc_tick) begin
			ph_ticks <= ph_ticks + 8'h01;
		end
	end

	property p_sample_len;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state == act_pkg::PH_SAMPLE && next_state == act_pkg::PH_CONVERT)
			|-> (ph_ticks + 8'h01 == {1'b0, sample_target});
	endproperty
	a_sample_len: assert property (p_sample_len) else $error("sample length wrong");

	property p_conv_len;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(state == act_pkg::PH_CONVERT && next_state == act_pkg::PH_LOAD)
			|-> (ph_ticks + 8'h01 == {1'b0, conv_target});
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

	sequence s_load_six;
		(state == act_pkg::PH_LOAD) [*6] ##1 (state == act_pkg::PH_IDLE);
	endsequence
	property p_load_len;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		$rose(state == act_pkg::PH_LOAD) |-> s_load_six;
	endproperty
	a_load_len: assert property (p_load_len) else $error("result load not six cycles");

	sequence s_to_convert;
		!SAMPLE_O && CONVERT_O;
	endsequence
	property p_order;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		$fell(SAMPLE_O) |-> s_to_convert;
	endproperty
	a_order: assert property (p_order) else $error("sample not followed by convert");

	property p_clamp_low;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(commit && ana_under) |=> (result == act_pkg::RES_ZERO) && res_valid;
	endproperty
	a_clamp_low: assert property (p_clamp_low) else $error("underrange not zero");

	property p_clamp_high;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(commit && ana_over && !ana_under) |=> (result == act_pkg::RES_FULL);
	endproperty
	a_clamp_high: assert property (p_clamp_high) else $error("overrange not full");

	property p_cal_bounds;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		$fell(cal_active) |-> (cal_cnt >= 14'(CAL_MIN_BC)) && (cal_cnt <= 14'(CAL_MAX_BC));
	endproperty
	a_cal_bounds: assert property (p_cal_bounds) else $error("calibration length out of range");

	property p_cal_hold;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		(cal_active && busy) |=> $stable(cal_cnt);
	endproperty
	a_cal_hold: assert property (p_cal_hold) else $error("calibration ran during conversion");

	property p_halving;
		@(posedge CLOCK_I) disable iff (!RST_N_I)
		wr_sys |-> ##2 (CPU_CLOCK_HALVING_O == $past(WDATA_I[0], 2));
	endproperty
	a_halving: assert property (p_halving) else $error("halving output not updated");
endmodule

// file: tb_act_timing.sv
`timescale 1ns/10ps
module tb_act_timing;
	typedef struct {
		logic [1:0] bcs;
		logic [1:0] sts;
		logic       res8;
		logic       poff;
		logic       imp;
		logic [3:0] idiv;
		logic [9:0] val;
		logic       under;
		logic       over;
		logic [9:0] res;
	} act_row_s;

	// ==========================================================
	// design ports and bench state
	logic        CLOCK_I = 1'b0;
	logic        RST_N_I = 1'b0;
	logic [3:0]  ADDR_I  = 4'h0;
	logic [15:0] WDATA_I = 16'h0000;
	logic        WR_I    = 1'b0;
	logic        RD_I    = 1'b0;
	logic [15:0] RDATA_O;
	logic [9:0]  ANA_RESULT_I;
	logic        ANA_UNDER_I;
	logic        ANA_OVER_I;
	logic        CAL_DONE_I;
	logic        SAMPLE_O;
	logic        CONVERT_O;
	logic        CAL_O;
	logic        BUSY_O;
	logic        CPU_CLOCK_HALVING_O;
	logic [1:0]  MASTER_CLOCK_CONFIG_O;
	logic [9:0]  set_val   = 10'h000;  // front end level
	logic        set_under = 1'b0;
	logic        set_over  = 1'b0;
	logic        settle    = 1'b0;     // reference settled
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;           // hang guard
	int          c;
	act_row_s    rows[9];

	act_timing #(.CAL_MIN_BC(4), .CAL_MAX_BC(40)) i_act_timing (
		.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ANA_RESULT_I(ANA_RESULT_I),
		.ANA_UNDER_I(ANA_UNDER_I), .ANA_OVER_I(ANA_OVER_I), .CAL_DONE_I(CAL_DONE_I),
		.SAMPLE_O(SAMPLE_O), .CONVERT_O(CONVERT_O), .CAL_O(CAL_O), .BUSY_O(BUSY_O),
		.CPU_CLOCK_HALVING_O(CPU_CLOCK_HALVING_O),
		.MASTER_CLOCK_CONFIG_O(MASTER_CLOCK_CONFIG_O));

	act_front_model i_act_front_model (
		.clk_i(CLOCK_I), .busy_i(BUSY_O), .val_i(set_val), .under_i(set_under),
		.over_i(set_over), .settle_i(settle), .result_o(ANA_RESULT_I),
		.under_o(ANA_UNDER_I), .over_o(ANA_OVER_I), .cal_done_o(CAL_DONE_I));

	// ==========================================================
	// clock and hang guard
	initial begin
		forever #2.5 CLOCK_I = ~CLOCK_I;
	end

	always @(posedge CLOCK_I) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			$display("[FAIL] %0t run hung", $time);
			tally_and_finish();
		end
	end

	// ==========================================================
	// report and compare
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t value %h wanted %h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		total_checks++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("[FAIL] %0t count %0d wanted %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// status pins packed: sample, convert, busy, cal, halving, master cfg
	function automatic logic [15:0] outs();
		return {9'h000, SAMPLE_O, CONVERT_O, BUSY_O, CAL_O, CPU_CLOCK_HALVING_O,
			MASTER_CLOCK_CONFIG_O};
	endfunction

	// ==========================================================
	// register port: one-cycle strobes, data the cycle after a read
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLOCK_I);
		ADDR_I  <= a;
		WDATA_I <= d;
		WR_I    <= 1'b1;
		@(posedge CLOCK_I);
		WR_I    <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge CLOCK_I);
		ADDR_I <= a;
		RD_I   <= 1'b1;
		@(posedge CLOCK_I);
		RD_I   <= 1'b0;
		@(negedge CLOCK_I);
		chk(RDATA_O, e);
	endtask

	task automatic do_reset();
		@(posedge CLOCK_I);
		RST_N_I <= 1'b0;
		repeat (3) @(posedge CLOCK_I);
		@(negedge CLOCK_I);
		chk(outs(), 16'h0008);
		@(posedge CLOCK_I);
		RST_N_I <= 1'b1;
	endtask

	// cycles until calibration drops, bounded
	task automatic cal_len(output int n);
		n = 0;
		while (CAL_O === 1'b1 && n < 400) begin
			@(negedge CLOCK_I);
			n++;
		end
	endtask

	// ==========================================================
	// one conversion: phase lengths, status, result
	task automatic run_conv(input act_row_s r, input logic cal);
		int ns, nc, nl, d, n, m;
		d = r.imp ? r.idiv + 2 : (r.bcs == 2'h0 ? 4 : r.bcs == 2'h1 ? 2 : r.bcs == 2'h2 ? 16 : 8);
		n = 8 << r.sts;
		m = (r.res8 ? 44 : 52) - (r.poff ? 12 : 0);
		ns = 0;
		nc = 0;
		nl = 0;
		set_val   <= r.val;
		set_under <= r.under;
		set_over  <= r.over;
		wr(act_pkg::ADDR_CTRL, {r.bcs, r.sts, 4'h0, r.idiv, r.imp, r.poff, r.res8, 1'b1});
		@(negedge CLOCK_I);
		while (BUSY_O === 1'b1 && nl < 50) begin
			if (SAMPLE_O === 1'b1) begin
				ns++;
			end else if (CONVERT_O === 1'b1) begin
				nc++;
			end else begin
				nl++;
			end
			@(negedge CLOCK_I);
		end
		// first basic period may be a leftover of the old divisor
		chk_rng(ns, (n - 1) * d + 1, (n - 1) * d + 16);
		chk_rng(nc, m * d, m * d);
		chk_rng(nl, 6, 6);
		rd_chk(act_pkg::ADDR_STAT, {13'h0000, 1'b1, cal, 1'b0});
		rd_chk(act_pkg::ADDR_RES, {6'h00, r.res});
	endtask

	// ==========================================================
	// main sequence
	initial begin
		// codes 00 and 01 break the basic clock ceiling at 200 MHz; run for ratio only
		rows[0] = '{2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0, 10'h2a5, 1'b0, 1'b0, 10'h2a5};
		rows[1] = '{2'h1, 2'h1, 1'b1, 1'b0, 1'b0, 4'h0, 10'h0c3, 1'b0, 1'b0, 10'h0c3};
		rows[2] = '{2'h2, 2'h2, 1'b0, 1'b1, 1'b0, 4'h0, 10'h155, 1'b0, 1'b0, 10'h155};
		rows[3] = '{2'h3, 2'h3, 1'b1, 1'b1, 1'b0, 4'h0, 10'h0aa, 1'b0, 1'b0, 10'h0aa};
		rows[4] = '{2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0, 10'h155, 1'b1, 1'b0, 10'h000};
		rows[5] = '{2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0, 10'h155, 1'b0, 1'b1, 10'h3ff};
		rows[6] = '{2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 4'h0, 10'h011, 1'b0, 1'b1, 10'h3ff};
		rows[7] = '{2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 4'h0, 10'h155, 1'b1, 1'b1, 10'h000};
		rows[8] = '{2'h0, 2'h1, 1'b0, 1'b1, 1'b1, 4'h1, 10'h3c3, 1'b0, 1'b0, 10'h3c3};
		do_reset();
		rd_chk(act_pkg::ADDR_CTRL, 16'h0000);
		rd_chk(act_pkg::ADDR_STAT, 16'h0002);
		rd_chk(act_pkg::ADDR_RES, 16'h0000);
		rd_chk(act_pkg::ADDR_SYS, 16'h0000);
		rd_chk(4'h2, 16'h0000);
		wr(act_pkg::ADDR_SYS, 16'h0005);
		wr(4'h6, 16'hffff);
		@(negedge CLOCK_I);
		chk(outs(), 16'h000e);
		rd_chk(act_pkg::ADDR_SYS, 16'h0005);
		rd_chk(act_pkg::ADDR_CTRL, 16'h0000);
		// conversion inside calibration runs and pushes calibration out
		run_conv(rows[0], 1'b1);
		chk({15'h0000, CAL_O}, 16'h0001);
		cal_len(c);
		chk_rng(c, 100, 170);
		for (int i = 0; i < 9; i++) begin
			run_conv(rows[i], 1'b0);
		end
		// result read has cleared the valid flag
		rd_chk(act_pkg::ADDR_STAT, 16'h0000);
		// start while busy is dropped, fields still land
		wr(act_pkg::ADDR_CTRL, 16'h0041);
		wr(act_pkg::ADDR_CTRL, 16'h0003);
		rd_chk(act_pkg::ADDR_CTRL, 16'h0002);
		rd_chk(act_pkg::ADDR_STAT, 16'h0001);
		c = 0;
		while (BUSY_O === 1'b1 && c < 1000) begin
			@(negedge CLOCK_I);
			c++;
		end
		repeat (10) @(negedge CLOCK_I);
		chk(outs(), 16'h0006);
		// reset in mid conversion, then calibration runs to its ceiling
		wr(act_pkg::ADDR_CTRL, 16'h8001);
		repeat (10) @(negedge CLOCK_I);
		do_reset();
		cal_len(c);
		chk_rng(c, 150, 170);
		// settled reference ends calibration at its floor
		settle <= 1'b1;
		do_reset();
		cal_len(c);
		chk_rng(c, 8, 30);
		tally_and_finish();
	end
endmodule
